/* design/acsc_conv_ctrl.sv */
// Conversion cycle and three-wire serial output control of the converter.
//
// Functional notes
// RULE_01: A low chip select enables the serial data driver and wakes the converter.
// RULE_02: After each conversion the converter sleeps while chip select stays high.
// RULE_03: Chip select rising during a transfer abandons it and starts a conversion.
// RULE_04: The serial data pin floats whenever chip select is high.
// RULE_05: During conversion and sleep the serial data pin shows conversion status.
// RULE_06: In internal clock mode the device drives the shift clock during output.
// RULE_07: In external clock mode the host supplies the shift clock during output.
// RULE_08: A weak pull-up on the clock pin is on whenever internal clock mode holds.
// RULE_09: Clock mode follows the clock pin level at power-up or chip select fall.
// RULE_10: A high frequency control pin selects the internal oscillator and 50 Hz null; with P_DUAL_REJECT set the code gives the dual null.
// RULE_11: A low frequency control pin gives a 60 Hz null, or 50 and 60 Hz dual.
// RULE_12: A clock on the frequency control pin is the system clock, null at f/2560.
// RULE_13: Each result transfer is one 32-bit serial word.
// RULE_14: Data changes on the falling clock edge and is latched on the rising one.
// RULE_15: Output ends after 32 bits or chip select rise, then a conversion starts.
// RULE_16: Busy shows high on the data pin, and low once a result is ready.
`timescale 1ns/1ps
`include "acsc_defines.svh"

module acsc_conv_ctrl #(
  parameter bit          P_DUAL_REJECT = 1'b0,
  parameter logic [21:0] P_CONV_50_CYC = 22'(`ACSC_CONV_50_US * `ACSC_CLK_MHZ),
  parameter logic [21:0] P_CONV_60_CYC = 22'(`ACSC_CONV_60_US * `ACSC_CLK_MHZ),
  parameter logic [21:0] P_CONV_DL_CYC = 22'(`ACSC_CONV_DUAL_US * `ACSC_CLK_MHZ),
  parameter logic [13:0] P_OSC_IDLE    = 14'(`ACSC_OSC_PHASE_US * `ACSC_CLK_MHZ + 1)
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_cs_n,
  input  wire logic                          i_sck,
  input  wire logic                          i_freq_control_pin,
  input  wire logic [`ACSC_WORD_BITS-1:0]    i_conv_result,
  output logic                               o_serial_out_pin,
  output logic                               o_serial_out_pin_oe,
  output logic                               o_sck,
  output logic                               o_sck_oe,
  output logic                               o_sck_pullup_en,
  output logic                               o_wake,
  output logic                               o_sleep,
  output logic                               o_conv_busy,
  output logic                               o_conv_done,
  output logic                               o_ext_sck_mode,
  output logic                               o_ext_osc,
  output logic [1:0]                         o_null_sel
);

  localparam logic [9:0]  ISCK_HALF    = 10'(`ACSC_CLK_HZ / (2 * `ACSC_ISCK_HZ));
  localparam logic [9:0]  ISCK_HALF_DL = 10'(`ACSC_CLK_HZ / (2 * `ACSC_ISCK_DUAL_HZ));
  localparam logic [9:0]  EXT_HALF     = 10'(`ACSC_EXT_HALF_TICKS);
  localparam logic [21:0] EXT_CONV     = 22'(`ACSC_EXT_CONV_TICKS);
  localparam logic [5:0]  LAST_BIT     = 6'(`ACSC_WORD_BITS - 1);
  localparam logic [1:0]  PWRUP_LAST   = 2'(`ACSC_PWRUP_CYC - 1);

  acsc_pkg::acsc_state_type state_r;
  acsc_pkg::acsc_state_type state_nxt;

  logic [1:0]                     sync1_r;
  logic [1:0]                     sync2_r;
  logic [1:0]                     sync3_r;
  logic [1:0]                     pin_r;
  logic [1:0]                     pin_nxt;
  logic                           cs_n;
  logic                           sck_in;
  logic                           sck_prev_r;
  logic                           cs_prev_r;
  logic                           cs_fall;
  logic                           esck_rise;
  logic                           esck_fall;
  logic [1:0]                     pwrup_r;
  logic                           pwrup_pend_r;
  logic                           pwrup_take;
  logic                           ext_sck_r;
  logic                           f0_ext;
  logic                           f0_level;
  logic                           f0_tick;
  logic [21:0]                    conv_cnt_r;
  logic [21:0]                    conv_target;
  logic                           conv_step;
  logic                           conv_done;
  logic [9:0]                     half_cnt_r;
  logic [9:0]                     half_target;
  logic                           half_step;
  logic                           isck_r;
  logic                           isck_toggle;
  logic                           bit_rise;
  logic                           bit_fall;
  logic [5:0]                     bit_cnt_r;
  logic                           word_end;
  logic [`ACSC_WORD_BITS-1:0]     shift_r;
  logic [`ACSC_WORD_BITS-1:0]     shift_nxt;
  logic                           sdo_r;
  logic                           sdo_nxt;
  logic                           in_out;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for chip select (bit 0) and the clock pin (bit 1).
  // A filtered level moves only once stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin_sync
      assign pin_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : pin_r[g];
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_r <= `ACSC_PIN_RST;
      sync2_r <= `ACSC_PIN_RST;
      sync3_r <= `ACSC_PIN_RST;
      pin_r   <= `ACSC_PIN_RST;
    end
    else
    begin
      sync1_r <= {i_sck, i_cs_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r   <= pin_nxt;
    end
  end

  // Edge detection on the filtered pin levels.
  assign cs_n      = pin_r[0];
  assign sck_in    = pin_r[1];
  assign cs_fall   = cs_prev_r & ~cs_n;
  assign esck_rise = ~sck_prev_r & sck_in;
  assign esck_fall = sck_prev_r & ~sck_in;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cs_prev_r  <= 1'b1;
      sck_prev_r <= 1'b1;
    end
    else
    begin
      cs_prev_r  <= cs_n;
      sck_prev_r <= sck_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock mode capture: once the synchronisers settle after reset, then at
  // every chip select fall. A high pin means the device drives the clock.
  assign pwrup_take = pwrup_pend_r & (pwrup_r == PWRUP_LAST);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pwrup_r      <= 2'h0;
      pwrup_pend_r <= 1'b1;
      ext_sck_r    <= 1'b0;
    end
    else
    begin
      pwrup_r <= pwrup_pend_r ? pwrup_r + 2'h1 : pwrup_r;
      if (pwrup_take)
        pwrup_pend_r <= 1'b0;
      // At power-up the filtered level still holds its reset value, so the
      // filter's next value is taken instead.
      if (pwrup_take)
        ext_sck_r <= ~pin_nxt[1];  // see RULE_09
      else if (cs_fall)
        ext_sck_r <= ~sck_in;      // see RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frequency control pin: strap level or external oscillator.
  acsc_freq_detect #(
    .P_IDLE_CYC (P_OSC_IDLE)
  ) u_freq_detect (
    .i_core_clk         (i_core_clk),
    .i_rst_n            (i_rst_n),
    .i_freq_control_pin (i_freq_control_pin),
    .o_ext_osc          (f0_ext),
    .o_level            (f0_level),
    .o_tick             (f0_tick)
  );

  // Filter null selection and the matching conversion length.
  assign o_null_sel  = f0_ext        ? acsc_pkg::ACSC_NULL_EXT :  // see RULE_12
                       P_DUAL_REJECT ? acsc_pkg::ACSC_NULL_5060 : // see RULE_11
                       f0_level      ? acsc_pkg::ACSC_NULL_50 :   // see RULE_10
                                       acsc_pkg::ACSC_NULL_60;    // see RULE_11
  assign conv_target = f0_ext        ? EXT_CONV :
                       P_DUAL_REJECT ? P_CONV_DL_CYC :
                       f0_level      ? P_CONV_50_CYC : P_CONV_60_CYC;
  assign conv_step   = (state_r == acsc_pkg::ACSC_ST_CONV) & (f0_ext ? f0_tick : 1'b1);
  assign conv_done   = conv_step & (conv_cnt_r == conv_target - 22'h00_0001);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer; the result word is captured when it expires.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      conv_cnt_r <= 22'h00_0000;
    else if (state_r != acsc_pkg::ACSC_ST_CONV || conv_done)
      conv_cnt_r <= 22'h00_0000;
    else if (conv_step)
      conv_cnt_r <= conv_cnt_r + 22'h00_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal shift clock: low at output start, toggling each half period,
  // paced by the core clock or by oscillator ticks at one eighth of its rate.
  assign in_out      = state_r == acsc_pkg::ACSC_ST_OUT;
  assign half_target = f0_ext ? EXT_HALF : (P_DUAL_REJECT ? ISCK_HALF_DL : ISCK_HALF);
  assign half_step   = f0_ext ? f0_tick : 1'b1;
  assign isck_toggle = in_out & ~ext_sck_r & half_step &
                       (half_cnt_r == half_target - 10'h001);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      half_cnt_r <= 10'h000;
      isck_r     <= 1'b0;
    end
    else if (!in_out || isck_toggle)
    begin
      half_cnt_r <= 10'h000;
      isck_r     <= in_out & ~isck_r;  // see RULE_06
    end
    else if (half_step)
    begin
      half_cnt_r <= half_cnt_r + 10'h001;
    end
  end

  // Shift events come from the internal clock or the host's clock.
  assign bit_rise = in_out & (ext_sck_r ? esck_rise : (isck_toggle & ~isck_r));  // see RULE_07
  assign bit_fall = in_out & (ext_sck_r ? esck_fall : (isck_toggle & isck_r));
  assign word_end = bit_rise & (bit_cnt_r == LAST_BIT);  // see RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // Operating cycle: conversion, sleep, data output.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      acsc_pkg::ACSC_ST_CONV:
        if (conv_done)
          state_nxt = acsc_pkg::ACSC_ST_SLEEP;  // see RULE_02
      acsc_pkg::ACSC_ST_SLEEP:
        if (!cs_n && !cs_fall)
          state_nxt = acsc_pkg::ACSC_ST_OUT;    // see RULE_01
      acsc_pkg::ACSC_ST_OUT:
        if (cs_n)
          state_nxt = acsc_pkg::ACSC_ST_CONV;   // see RULE_03
        else if (word_end)
          state_nxt = acsc_pkg::ACSC_ST_CONV;   // see RULE_15
      default:
        state_nxt = acsc_pkg::ACSC_ST_CONV;
    endcase
  end

  // Shift register: loaded at the end of conversion, advanced on falling edges.
  assign shift_nxt = conv_done                          ? i_conv_result :
                     (bit_fall && bit_cnt_r != 6'h00)   ? {shift_r[`ACSC_WORD_BITS-2:0], 1'b0} :
                                                          shift_r;  // see RULE_14

  // Data pin value: status while converting or sleeping, result bits in output.
  assign sdo_nxt = (state_nxt == acsc_pkg::ACSC_ST_OUT)  ? shift_nxt[`ACSC_WORD_BITS-1] :
                   (state_nxt == acsc_pkg::ACSC_ST_CONV) ? 1'b1 : 1'b0;  // see RULE_05, RULE_16

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r   <= acsc_pkg::ACSC_ST_CONV;
      shift_r   <= 32'h0000_0000;
      bit_cnt_r <= 6'h00;
      sdo_r     <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      shift_r   <= shift_nxt;
      sdo_r     <= sdo_nxt;
      if (!in_out)
        bit_cnt_r <= 6'h00;
      else if (bit_rise)
        bit_cnt_r <= bit_cnt_r + 6'h01;  // see RULE_15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and status outputs.
  assign o_serial_out_pin    = sdo_r;
  assign o_serial_out_pin_oe = ~cs_n;                      // see RULE_04, RULE_01
  assign o_sck               = isck_r;
  assign o_sck_oe            = in_out & ~ext_sck_r & ~cs_n; // see RULE_06
  assign o_sck_pullup_en     = ~ext_sck_r;                 // see RULE_08
  assign o_wake              = ~cs_n;                      // see RULE_01
  assign o_sleep             = (state_r == acsc_pkg::ACSC_ST_SLEEP) & cs_n;  // see RULE_02
  assign o_conv_busy         = state_r == acsc_pkg::ACSC_ST_CONV;
  assign o_conv_done         = conv_done;
  assign o_ext_sck_mode      = ext_sck_r;
  assign o_ext_osc           = f0_ext;

endmodule : acsc_conv_ctrl

/* design/acsc_defines.svh */
// Timing and format constants for the converter serial conversion control.
`ifndef ACSC_DEFINES_SVH
`define ACSC_DEFINES_SVH

// Core clock rate in MHz and in Hz.
`define ACSC_CLK_MHZ        25
`define ACSC_CLK_HZ         25000000

// Conversion times on the internal oscillator, in microseconds.
`define ACSC_CONV_50_US     80120
`define ACSC_CONV_60_US     66770
`define ACSC_CONV_DUAL_US   72800

// Conversion length on an external oscillator, in oscillator periods.
`define ACSC_EXT_CONV_TICKS 10278

// Internal shift clock rates in Hz, and oscillator ticks per half period.
`define ACSC_ISCK_HZ        19200
`define ACSC_ISCK_DUAL_HZ   17500
`define ACSC_EXT_HALF_TICKS 4

// Result word length in bits.
`define ACSC_WORD_BITS      32

// Longest external oscillator phase, in microseconds.
`define ACSC_OSC_PHASE_US   390

// Sampling of the clock pin after reset release, in core cycles.
`define ACSC_PWRUP_CYC      4

// Reset levels of the filtered pins: chip select idle high, clock pulled up.
`define ACSC_PIN_RST        2'b11

`endif

/* design/acsc_pkg.sv */
// Types shared by the converter serial conversion control.
package acsc_pkg;

  // Converter operating cycle.
  typedef enum logic [1:0] {
    ACSC_ST_CONV  = 2'b00,
    ACSC_ST_SLEEP = 2'b01,
    ACSC_ST_OUT   = 2'b10
  } acsc_state_type;

  // Position of the first filter null.
  typedef enum logic [1:0] {
    ACSC_NULL_60   = 2'b00,
    ACSC_NULL_50   = 2'b01,
    ACSC_NULL_5060 = 2'b10,
    ACSC_NULL_EXT  = 2'b11
  } acsc_null_type;

endpackage : acsc_pkg

/* design/acsc_freq_detect.sv */
// Frequency control pin synchroniser and external oscillator detector.
`timescale 1ns/1ps
`include "acsc_defines.svh"

module acsc_freq_detect #(
  parameter logic [13:0] P_IDLE_CYC = 14'(`ACSC_OSC_PHASE_US * `ACSC_CLK_MHZ + 1)
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_freq_control_pin,
  output logic      o_ext_osc,
  output logic      o_level,
  output logic      o_tick
);

  logic [2:0]  sync_r;
  logic        level_r;
  logic        ext_r;
  logic        armed_r;
  logic [13:0] idle_r;
  logic        level_nxt;
  logic        edge_w;
  logic        rise_w;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser; the level moves only when stages two and three agree.
  assign level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
  assign edge_w    = level_nxt != level_r;
  assign rise_w    = edge_w & level_nxt;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_r  <= 3'h0;
      level_r <= 1'b0;
    end
    else
    begin
      sync_r  <= {sync_r[1:0], i_freq_control_pin};
      level_r <= level_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A pin that keeps toggling is an oscillator; one that rests is a strap.
  // A lone edge only arms the detector, so a strap settling after reset or
  // moved by hand never reads as an oscillator; a second edge in time does.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ext_r   <= 1'b0;
      armed_r <= 1'b0;
      idle_r  <= 14'h0000;
    end
    else if (edge_w)
    begin
      ext_r   <= armed_r;  // see RULE_12
      armed_r <= 1'b1;
      idle_r  <= 14'h0000;
    end
    else if (idle_r == P_IDLE_CYC)
    begin
      ext_r   <= 1'b0;     // see RULE_10
      armed_r <= 1'b0;
    end
    else
    begin
      idle_r <= idle_r + 14'h0001;
    end
  end

  // Rising oscillator edges pace conversion and shift clock in external mode.
  assign o_ext_osc = ext_r;
  assign o_level   = level_r;
  assign o_tick    = rise_w & ext_r;

endmodule : acsc_freq_detect

/* verif/acsc_conv_ctrl_assertions.sv */
// Concurrent checks on the ports of the conversion control.
`timescale 1ns/1ps

module acsc_conv_ctrl_assertions (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_freq_control_pin,
  input  wire logic       o_serial_out_pin,
  input  wire logic       o_serial_out_pin_oe,
  input  wire logic       o_sck,
  input  wire logic       o_sck_oe,
  input  wire logic       o_sck_pullup_en,
  input  wire logic       o_wake,
  input  wire logic       o_sleep,
  input  wire logic       o_conv_busy,
  input  wire logic       o_conv_done,
  input  wire logic       o_ext_sck_mode,
  input  wire logic       o_ext_osc,
  input  wire logic [1:0] o_null_sel
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;
  logic       sck_q_r;

  // Counts driven clock rises within one word so a long word is caught.
  assign rise_cnt_nxt = o_sck_oe ? rise_cnt_r + {5'h00, o_sck & ~sck_q_r} : 6'h00;

  // Holds the counter and the previous clock level.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rise_cnt_r <= 6'h00;
      sck_q_r    <= 1'b0;
    end
    else
    begin
      rise_cnt_r <= rise_cnt_nxt;
      sck_q_r    <= o_sck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_oe_wake_tie: assert property (o_serial_out_pin_oe == o_wake)
    else $error("data driver and wake disagree");
  a_done_then_sleep: assert property (o_conv_done |=> !o_conv_busy &&
    (o_sleep || o_serial_out_pin_oe)) else $error("no sleep after conversion");
  a_cs_high_float: assert property (i_cs_n [*6] |-> !o_serial_out_pin_oe &&
    !o_sck_oe) else $error("pins driven with chip select high");
  a_busy_shows_high: assert property (o_conv_busy && o_serial_out_pin_oe |->
    o_serial_out_pin) else $error("busy status not high");
  a_sck_drive_mode: assert property (o_sck_oe |-> !o_ext_sck_mode &&
    o_serial_out_pin_oe && !o_conv_busy) else $error("clock driven outside output");
  a_pullup_mode: assert property (o_sck_pullup_en != o_ext_sck_mode)
    else $error("pull-up does not follow clock mode");
  a_data_on_fall: assert property (o_sck_oe && $past(o_sck_oe) &&
    $changed(o_serial_out_pin) |-> $fell(o_sck)) else $error("data moved off falling edge");
  a_word_length: assert property (rise_cnt_r <= 6'h20)
    else $error("more than one word of clock rises");
  a_null_ext: assert property (o_ext_osc |-> o_null_sel == 2'b11)
    else $error("oscillator null select wrong");
  a_null_high: assert property ((!o_ext_osc && i_freq_control_pin) [*8] |->
    o_null_sel == 2'b01) else $error("high pin null select wrong");
  a_null_low: assert property ((!o_ext_osc && !i_freq_control_pin) [*8] |->
    o_null_sel == 2'b00) else $error("low pin null select wrong");
endmodule : acsc_conv_ctrl_assertions

/* verif/acsc_host_model.sv */
// Host controller model that reads result words over the three-wire port.
`timescale 1ns/1ps

module acsc_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_sdo,
  input  wire logic i_sck,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_sck_oe,
  output logic      o_fault
);
  // Idle host: chip select high, clock pin strapped high.
  initial
  begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b1;
    o_sck_oe = 1'b1;
    o_fault  = 1'b0;
  end

  // Waits at most n cycles for the data (sel) or clock pin to show v.
  task automatic wait_pin(input bit sel, input logic v, input int n);
    int k;
    k = 0;
    while (((sel ? i_sdo : i_sck) !== v) && k < n)
    begin
      @(negedge i_core_clk);
      k++;
    end
    if ((sel ? i_sdo : i_sck) !== v)
      o_fault = 1'b1;
  endtask : wait_pin

  // Reads the first nbits of a word in either clock mode, then raises chip select.
  task automatic read_word(input bit ext, input int nbits, output logic [31:0] w);
    int i;
    w        = 32'h0000_0000;
    o_sck_oe = 1'b1;
    o_sck    = !ext;
    repeat (4) @(negedge i_core_clk);
    o_cs_n = 1'b0;
    // Released once the mode is latched, before the device drives the pin.
    repeat (5) @(negedge i_core_clk);
    o_sck_oe = ext;
    // Conversion lasts 200 cycles in this bench, so 260 covers it.
    if (ext)
      repeat (260) @(negedge i_core_clk);
    for (i = 0; i < nbits; i++)
    begin
      if (ext)
      begin
        repeat (6) @(negedge i_core_clk);
        w[31-i] = i_sdo;
        o_sck   = 1'b1;
        repeat (6) @(negedge i_core_clk);
        o_sck = 1'b0;
      end
      else
      begin
        wait_pin(1'b0, 1'b0, 1400);
        w[31-i] = i_sdo;
        wait_pin(1'b0, 1'b1, 1400);
      end
    end
    repeat (4) @(negedge i_core_clk);
    o_cs_n   = 1'b1;
  endtask : read_word
endmodule : acsc_host_model

/* verif/acsc_conv_ctrl_bench.sv */
// Self-checking bench for the converter serial conversion control.
`timescale 1ns/1ps

module acsc_conv_ctrl_bench;
  logic        i_core_clk;
  logic        i_rst_n;
  logic        i_freq_control_pin;
  logic [31:0] i_conv_result;
  logic        h_cs_n, h_sck, h_sck_oe, h_fault, tgl, sck_w, sdo_w;
  logic        o_serial_out_pin, o_serial_out_pin_oe, o_sck, o_sck_oe, o_sck_pullup_en;
  logic        o_wake, o_sleep, o_conv_busy, o_conv_done, o_ext_sck_mode, o_ext_osc;
  logic [1:0]  o_null_sel;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          n_checks = 0;

  // Pin levels: released pins show the pull-up or a changing pattern.
  assign sck_w = o_sck_oe ? o_sck : (h_sck_oe ? h_sck : (o_sck_pullup_en ? 1'b1 : tgl));
  assign sdo_w = o_serial_out_pin_oe ? o_serial_out_pin : tgl;

  acsc_conv_ctrl #(.P_DUAL_REJECT(1'b0), .P_CONV_50_CYC(22'h00_00c8),
    .P_CONV_60_CYC(22'h00_00c8), .P_CONV_DL_CYC(22'h00_00c8), .P_OSC_IDLE(14'h0028))
  acsc_conv_ctrl_i (.i_core_clk, .i_rst_n, .i_cs_n(h_cs_n), .i_sck(sck_w),
    .i_freq_control_pin, .i_conv_result, .o_serial_out_pin, .o_serial_out_pin_oe, .o_sck,
    .o_sck_oe, .o_sck_pullup_en, .o_wake, .o_sleep, .o_conv_busy, .o_conv_done,
    .o_ext_sck_mode, .o_ext_osc, .o_null_sel);

  acsc_host_model host_i (.i_core_clk, .i_sdo(sdo_w), .i_sck(sck_w), .o_cs_n(h_cs_n),
    .o_sck(h_sck), .o_sck_oe(h_sck_oe), .o_fault(h_fault));

  // Free-running clock at 25 MHz.
  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  // Pattern that changes every cycle for released pins.
  always @(posedge i_core_clk) tgl <= ~tgl;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // Reads a word or its leading bits and compares with the model, then loads a new result.
  task automatic do_read(input bit ext, input int nbits);
    logic [31:0] w;
    logic [31:0] m;
    m = 32'hffff_ffff << (32 - nbits);
    host_i.read_word(ext, nbits, w);
    check(w & m, exp_q.pop_front() & m);
    check(h_fault, 1'b0);
    seed          = lfsr(seed);
    i_conv_result = seed;
    exp_q.push_back(seed);
  endtask : do_read

  // Main sequence.
  initial
  begin
    tgl                = 1'b0;
    i_rst_n            = 1'b0;
    i_freq_control_pin = 1'b1;
    seed               = 32'hc209_6158;
    i_conv_result      = seed;
    exp_q.push_back(seed);
    repeat (12) @(negedge i_core_clk);
    check(o_sck_pullup_en, 1'b1);
    check({o_conv_busy, o_serial_out_pin_oe}, 2'b10);
    i_rst_n = 1'b1;
    fork
      do_read(1'b1, 32);
      begin
        repeat (20) @(negedge i_core_clk);
        check({sdo_w, o_wake, o_ext_sck_mode}, 3'b111);
      end
    join
    repeat (3) do_read(1'b1, 32);
    do_read(1'b1, 9);
    repeat (8) @(negedge i_core_clk);
    check({o_conv_busy, o_serial_out_pin_oe}, 2'b10);
    repeat (250) @(negedge i_core_clk);
    check({o_sleep, o_conv_busy}, 2'b10);
    fork
      do_read(1'b0, 32);
      begin
        repeat (40) @(negedge i_core_clk);
        check({o_sck_oe, o_ext_sck_mode}, 2'b10);
      end
    join
    do_read(1'b0, 3);
    i_freq_control_pin = 1'b0;
    repeat (12) @(negedge i_core_clk);
    check(o_null_sel, 2'b00);
    repeat (20)
    begin
      repeat (4) @(negedge i_core_clk);
      i_freq_control_pin = ~i_freq_control_pin;
    end
    check({o_ext_osc, o_null_sel}, 3'b111);
    i_freq_control_pin = 1'b1;
    repeat (60) @(negedge i_core_clk);
    check({o_ext_osc, o_null_sel}, 3'b001);
    results();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (100000) @(posedge i_core_clk);
    err_count++;
    results();
  end
endmodule : acsc_conv_ctrl_bench

bind acsc_conv_ctrl acsc_conv_ctrl_assertions acsc_conv_ctrl_assertions_i (.i_core_clk,
  .i_rst_n, .i_cs_n, .i_freq_control_pin, .o_serial_out_pin, .o_serial_out_pin_oe, .o_sck,
  .o_sck_oe, .o_sck_pullup_en, .o_wake, .o_sleep, .o_conv_busy, .o_conv_done,
  .o_ext_sck_mode, .o_ext_osc, .o_null_sel);
